// ==== logic/smbsp_bit_capture.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Bit capture on the bus clock
// ----------------------------------------------------------------
module smbsp_bit_capture
	import smbsp_pkg::*;
(
	// Link clock and reset
	input wire logic sclClock,
	input wire logic reset,
	// Data line
	input wire logic sdaPin,
	// Captured bit toward the system clock
	output logic bitToggle,
	output logic bitValue
);

	// Sample data on each rising bus clock; the toggle marks a new bit.
	// The value holds a whole bus clock period, so it crosses safely.
	always_ff @(posedge sclClock or posedge reset)
	begin
		if (reset)
		begin
			bitToggle <= 1'b1;
			bitValue <= 1'b0;
		end
		else
		begin
			bitValue <= sdaPin;
			bitToggle <= ~bitToggle;
		end
	end

endmodule : smbsp_bit_capture

// ==== logic/smbsp_pkg.sv ====
// ----------------------------------------------------------------
// Shared constants for the serial register port
// ----------------------------------------------------------------
package smbsp_pkg;

	// ----------------------------------------------------------------
	// Slave addresses
	// ----------------------------------------------------------------
	localparam logic [6:0] DEFAULT_ADDR = 7'h2E;
	localparam logic [6:0] STRAP_ADDR_LOW = 7'h2C;
	localparam logic [6:0] STRAP_ADDR_HIGH = 7'h2D;
	localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0C;
	localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
	localparam int ADDR_MATCH_BITS = 5;

	// ----------------------------------------------------------------
	// Byte framing
	// ----------------------------------------------------------------
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] FRAME_EDGE_BITS = 4'h1;
	localparam logic [7:0] UNDEFINED_DATA = 8'h00;
	localparam logic [0:0] READ_BIT = 1'h1;

	// Position of each byte within a transaction
	localparam logic [1:0] BYTE_ADDR = 2'h0;
	localparam logic [1:0] BYTE_REG = 2'h1;
	localparam logic [1:0] BYTE_DATA = 2'h2;
	localparam logic [1:0] BYTE_EXTRA = 2'h3;

	// ----------------------------------------------------------------
	// Synchroniser lanes
	// ----------------------------------------------------------------
	localparam int SYNC_SCL = 0;
	localparam int SYNC_SDA = 1;
	localparam int SYNC_STRAP_EN = 2;
	localparam int SYNC_STRAP_LVL = 3;
	localparam int SYNC_TOGGLE = 4;
	localparam int SYNC_BIT = 5;
	localparam int SYNC_WIDTH = 6;

	// Cycles after reset release before the straps are trusted
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLOCK_HZ = 50_000_000;
	localparam int TIMEOUT_MIN_US = 25_000;
	localparam int TIMEOUT_MAX_US = 35_000;
	// Least time: round up to whole cycles
	localparam int TIMEOUT_CYCLES = ((CLOCK_HZ / 1000) * TIMEOUT_MIN_US + 999) / 1000;
	localparam int TIMEOUT_WIDTH = 21;

	// ----------------------------------------------------------------
	// Protocol states
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_RX = 6'b000010,
		ST_ACK = 6'b000100,
		ST_TX = 6'b001000,
		ST_TXACK = 6'b010000,
		ST_IGNORE = 6'b100000
	} smbsp_state_t;

endpackage : smbsp_pkg

// ==== logic/smbsp_register_port.sv ====
`timescale 1ns/10ps
// Function
// - Without address strap, answer slave address 0101110b.
// - Strap enable low at power up selects strap addressing from strap level.
// - Strap level low gives 0101100b, high gives 0101101b.
// - Latch strapped address at first transaction matching our top five bits.
// - Strap mode disables fan four tach input and fan three PWM output.
// - Seven-bit address, eight-bit register and data, MSB first.
// - Write Byte: ack each byte; commit data only after full sequence.
// - Read Byte: register, repeated start, read, one driven byte.
// - Send Byte only loads the register pointer, never writes data.
// - Receive Byte returns pointed register and leaves pointer unchanged.
// - Send plus Receive returns the same register as Read Byte.
// - Invalid protocols leave registers; update only after valid completion.
// - Unknown address or invalid protocol: no acknowledge, back to idle.
// - Answer alert response address only while an alert is pending.
// - Undefined registers read 00h; writes there acknowledged and ignored.
// - Never acknowledge the general call address.
// - Clock low beyond 25 ms aborts; ready for START within 35 ms.
// - START then STOP resets the slave interface to idle.
// - Never stretch the clock; tolerate others stretching it.
// - After answering alert response, clear the alert interrupt enable; here pulsed once the address byte arrives, before the ACK.
module smbsp_register_port
	import smbsp_pkg::*;
#(
	parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES
)
(
	// System clock, reset and enable
	input wire logic clock,
	input wire logic reset,
	input wire logic clockEnable,
	// Bus pins
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOeN,
	// Address straps
	input wire logic strapEnableN,
	input wire logic strapLevel,
	// Pin function enables
	output logic fan4TachEnable,
	output logic fan3PwmEnable,
	// Register file access
	output logic [7:0] regAddr,
	output logic [7:0] regWriteData,
	output logic regWriteStrobe,
	input wire logic [7:0] regReadData,
	input wire logic regDefined,
	// Alert
	input wire logic alertPending,
	output logic alertIntEnableClear
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	smbsp_state_t state;
	logic [SYNC_WIDTH-1:0] syncFirst;
	logic [SYNC_WIDTH-1:0] syncLast;
	logic sclPrev;
	logic sdaPrev;
	logic toggleSeen;
	logic bitToggle;
	logic bitValue;
	logic [1:0] powerCount;
	logic strapReady;
	logic strapMode;
	logic addrLatched;
	logic [6:0] latchedAddr;
	logic [3:0] bitCount;
	logic [7:0] rxShift;
	logic [7:0] txShift;
	logic [1:0] byteIndex;
	logic readMode;
	logic ackOn;
	logic sdaLow;
	logic [7:0] pendingPointer;
	logic [7:0] pendingData;
	logic [TIMEOUT_WIDTH-1:0] lowCount;
	logic sclHigh;
	logic sclFall;
	logic startCond;
	logic stopCond;
	logic bitEvent;
	logic byteDone;
	logic frameEdge;
	logic timeoutHit;
	logic [7:0] rxByte;
	logic [6:0] strapAddr;
	logic [6:0] ownAddr;
	logic isOwn;
	logic isAlert;
	logic ackWanted;

	// Upper address bits agree
	function automatic logic topBitsMatch(input logic [6:0] a, input logic [6:0] b);
		topBitsMatch = a[6:7-ADDR_MATCH_BITS] == b[6:7-ADDR_MATCH_BITS];
	endfunction : topBitsMatch

	// ----------------------------------------------------------------
	// Link clock domain
	// ----------------------------------------------------------------
	smbsp_bit_capture capture (
		.sclClock(sclIn),
		.reset(reset),
		.sdaPin(sdaIn),
		.bitToggle(bitToggle),
		.bitValue(bitValue)
	);

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	// Two flops per lane; only the second is read
	generate
		for (genvar i = 0; i < SYNC_WIDTH; i++)
		begin : gen_sync
			logic rawIn;
			if (i == SYNC_SCL)
			begin : g_scl
				assign rawIn = sclIn;
			end
			else if (i == SYNC_SDA)
			begin : g_sda
				assign rawIn = sdaIn;
			end
			else if (i == SYNC_STRAP_EN)
			begin : g_sen
				assign rawIn = strapEnableN;
			end
			else if (i == SYNC_STRAP_LVL)
			begin : g_slv
				assign rawIn = strapLevel;
			end
			else if (i == SYNC_TOGGLE)
			begin : g_tog
				assign rawIn = bitToggle;
			end
			else
			begin : g_bit
				assign rawIn = bitValue;
			end
			always_ff @(posedge clock or posedge reset)
			begin
				if (reset)
				begin
					syncFirst[i] <= 1'b1;
					syncLast[i] <= 1'b1;
				end
				else if (clockEnable)
				begin
					syncFirst[i] <= rawIn;
					syncLast[i] <= syncFirst[i];
				end
			end
		end
	endgenerate

	// Previous samples for edge detection
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
			toggleSeen <= 1'b1;
		end
		else if (clockEnable)
		begin
			sclPrev <= syncLast[SYNC_SCL];
			sdaPrev <= syncLast[SYNC_SDA];
			toggleSeen <= syncLast[SYNC_TOGGLE];
		end
	end

	// ----------------------------------------------------------------
	// Bus events
	// ----------------------------------------------------------------
	// Data edges while the clock is high frame the transfer; the device
	// only moves its own data line while the clock is low, so it never
	// fakes one of these itself.
	always_comb
	begin
		sclHigh = syncLast[SYNC_SCL];
		sclFall = sclPrev & ~syncLast[SYNC_SCL];
		startCond = strapReady & sclHigh & sclPrev & sdaPrev & ~syncLast[SYNC_SDA];
		stopCond = sclHigh & sclPrev & ~sdaPrev & syncLast[SYNC_SDA];
		bitEvent = syncLast[SYNC_TOGGLE] ^ toggleSeen;
		byteDone = (state == ST_RX) & bitEvent & (bitCount == LAST_BIT);
		frameEdge = (state == ST_RX) & (bitCount <= FRAME_EDGE_BITS);
		timeoutHit = lowCount == TIMEOUT_WIDTH'(TIMEOUT_LIMIT - 1);
		rxByte = {rxShift[6:0], syncLast[SYNC_BIT]};
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	always_comb
	begin
		strapAddr = syncLast[SYNC_STRAP_LVL] ? STRAP_ADDR_HIGH : STRAP_ADDR_LOW;
		if (!strapMode)
			ownAddr = DEFAULT_ADDR;
		else if (addrLatched)
			ownAddr = latchedAddr;
		else
			ownAddr = strapAddr;
		// General call is never acked
		isOwn = (rxByte[7:1] == ownAddr) & (rxByte[7:1] != GENERAL_CALL_ADDR);
		isAlert = (rxByte[7:1] == ALERT_RESPONSE_ADDR) & alertPending & rxByte[0];
		unique case (byteIndex)
			BYTE_ADDR: ackWanted = isOwn | isAlert;
			BYTE_REG: ackWanted = 1'b1;
			BYTE_DATA: ackWanted = 1'b1;
			default: ackWanted = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Straps
	// ----------------------------------------------------------------
	// Straps are caught a few cycles after release, once the synchronised
	// level is the real pin
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			powerCount <= 2'h0;
			strapReady <= 1'b0;
			strapMode <= 1'b0;
		end
		else if (clockEnable && !strapReady)
		begin
			powerCount <= powerCount + 2'h1;
			if (powerCount == STRAP_SETTLE)
			begin
				strapReady <= 1'b1;
				strapMode <= ~syncLast[SYNC_STRAP_EN];
			end
		end
	end

	// Latch the strapped address once; later glitches cannot move it
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			addrLatched <= 1'b0;
			latchedAddr <= DEFAULT_ADDR;
		end
		else if (clockEnable && byteDone && byteIndex == BYTE_ADDR)
		begin
			if (strapMode && !addrLatched && topBitsMatch(rxByte[7:1], strapAddr))
			begin
				addrLatched <= 1'b1;
				latchedAddr <= strapAddr;
			end
		end
	end

	// Pins borrowed by the straps lose their fan function
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			fan4TachEnable <= 1'b0;
			fan3PwmEnable <= 1'b0;
		end
		else if (clockEnable)
		begin
			fan4TachEnable <= strapReady & ~strapMode;
			fan3PwmEnable <= strapReady & ~strapMode;
		end
	end

	// ----------------------------------------------------------------
	// Protocol state machine
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			state <= ST_IDLE;
			bitCount <= 4'h0;
			rxShift <= 8'h00;
			byteIndex <= BYTE_ADDR;
			readMode <= 1'b0;
			ackOn <= 1'b0;
		end
		else if (clockEnable)
		begin
			if (startCond)
			begin
				// Also the repeated start of Read Byte
				state <= ST_RX;
				bitCount <= 4'h0;
				byteIndex <= BYTE_ADDR;
				ackOn <= 1'b0;
			end
			else if (stopCond || timeoutHit)
			begin
				state <= ST_IDLE;
				ackOn <= 1'b0;
			end
			else
			begin
				unique case (state)
					ST_IDLE:
					begin
						bitCount <= 4'h0;
					end
					ST_RX:
					begin
						if (bitEvent)
						begin
							rxShift <= rxByte;
							bitCount <= bitCount + 4'h1;
							if (bitCount == LAST_BIT)
							begin
								state <= ackWanted ? ST_ACK : ST_IGNORE;
								if (byteIndex == BYTE_ADDR)
									readMode <= rxByte[0] == READ_BIT;
							end
						end
					end
					ST_ACK:
					begin
						if (sclFall)
						begin
							ackOn <= ~ackOn;
							if (ackOn)
							begin
								bitCount <= 4'h0;
								state <= readMode ? ST_TX : ST_RX;
								if (byteIndex != BYTE_EXTRA)
									byteIndex <= byteIndex + 2'h1;
							end
						end
					end
					ST_TX:
					begin
						if (sclFall)
						begin
							bitCount <= bitCount + 4'h1;
							if (bitCount == LAST_BIT)
								state <= ST_TXACK;
						end
					end
					ST_TXACK:
					begin
						// One byte only
						if (bitEvent)
							state <= ST_IGNORE;
					end
					ST_IGNORE:
					begin
						bitCount <= 4'h0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit data
	// ----------------------------------------------------------------
	// Read data is taken when the address byte completes, while the
	// pointer is already settled
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			txShift <= UNDEFINED_DATA;
		else if (clockEnable)
		begin
			if (byteDone && byteIndex == BYTE_ADDR)
			begin
				if (isAlert)
					txShift <= {ownAddr, READ_BIT};
				else
					txShift <= regDefined ? regReadData : UNDEFINED_DATA;
			end
			else if (state == ST_TX && sclFall)
				txShift <= {txShift[6:0], 1'b0};
		end
	end

	// ----------------------------------------------------------------
	// Data line drive
	// ----------------------------------------------------------------
	// Only a low is ever driven, and only while the clock is low; the
	// clock line is never touched, so it is never stretched
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			sdaLow <= 1'b0;
		else if (clockEnable)
		begin
			if (startCond || stopCond || timeoutHit)
				sdaLow <= 1'b0;
			else if (state == ST_ACK && sclFall)
				sdaLow <= ackOn ? (readMode & ~txShift[7]) : 1'b1;
			else if (state == ST_TX && sclFall)
				sdaLow <= (bitCount != LAST_BIT) & ~txShift[6];
			else if (state == ST_IGNORE || state == ST_IDLE)
				sdaLow <= 1'b0;
		end
	end

	// Open-drain output: level always low, enable active low
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			sdaOut <= 1'b0;
			sdaOeN <= 1'b1;
		end
		else if (clockEnable)
		begin
			sdaOut <= 1'b0;
			sdaOeN <= ~sdaLow;
		end
	end

	// ----------------------------------------------------------------
	// Pointer and write commit
	// ----------------------------------------------------------------
	// Register and data bytes are held aside; nothing reaches the
	// register file unless the transaction ends legally
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			pendingPointer <= 8'h00;
			pendingData <= 8'h00;
		end
		else if (clockEnable && byteDone && !readMode)
		begin
			if (byteIndex == BYTE_REG)
				pendingPointer <= rxByte;
			else if (byteIndex == BYTE_DATA)
				pendingData <= rxByte;
		end
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			regAddr <= 8'h00;
			regWriteData <= 8'h00;
			regWriteStrobe <= 1'b0;
		end
		else if (clockEnable)
		begin
			regWriteStrobe <= 1'b0;
			// Send Byte ends here, or Read Byte restarts here
			if ((stopCond || startCond) && frameEdge && byteIndex == BYTE_DATA)
				regAddr <= pendingPointer;
			// Write Byte completed with its stop
			if (stopCond && frameEdge && byteIndex == BYTE_EXTRA)
			begin
				regAddr <= pendingPointer;
				regWriteData <= pendingData;
				regWriteStrobe <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Alert release
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			alertIntEnableClear <= 1'b0;
		else if (clockEnable)
			alertIntEnableClear <= byteDone & (byteIndex == BYTE_ADDR) & isAlert;
	end

	// ----------------------------------------------------------------
	// Clock-low timeout
	// ----------------------------------------------------------------
	// Counts only inside a transfer; the abort releases the bus at once,
	// well inside the ready limit
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			lowCount <= '0;
		else if (clockEnable)
		begin
			if (sclHigh || state == ST_IDLE || timeoutHit)
				lowCount <= '0;
			else
				lowCount <= lowCount + 1'b1;
		end
	end

endmodule : smbsp_register_port

// ==== tb/smbsp_chk.sv ====
`timescale 1ns/10ps
// ------------------------------------
// Port checker
// ------------------------------------
module smbsp_chk
	import smbsp_pkg::*;
#(
	parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES
)
(
	// System
	input wire logic clock,
	input wire logic reset,
	input wire logic clockEnable,
	// Bus
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOeN,
	// Straps and pin functions
	input wire logic strapEnableN,
	input wire logic strapLevel,
	input wire logic fan4TachEnable,
	input wire logic fan3PwmEnable,
	// Register file
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWriteData,
	input wire logic regWriteStrobe,
	input wire logic [7:0] regReadData,
	input wire logic regDefined,
	// Alert
	input wire logic alertPending,
	input wire logic alertIntEnableClear
);
	int lowCount;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// Clock-low length, saturating
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset || sclIn)
			lowCount <= 0;
		else if (lowCount < TIMEOUT_LIMIT + 100)
			lowCount <= lowCount + 1;
	end
	// Commits land only on a resting bus
	sequence s_busIdle; sclIn && sdaIn; endsequence
	sequence s_noStrobe; !regWriteStrobe [*8]; endsequence
	sequence s_noClear; !alertIntEnableClear [*8]; endsequence
	property p_pullOnly; !sdaOeN |-> !sdaOut; endproperty
	property p_drvInLow; !$stable(sdaOeN) |-> !sclIn; endproperty
	property p_commitIdle; regWriteStrobe |-> s_busIdle; endproperty
	property p_strobeOnce; regWriteStrobe |=> s_noStrobe; endproperty
	property p_ptrMove; !$stable(regAddr) |-> sclIn; endproperty
	property p_dataMove; !$stable(regWriteData) |-> s_busIdle; endproperty
	property p_strapFans; fan4TachEnable |-> strapEnableN && fan3PwmEnable; endproperty
	property p_clear; alertIntEnableClear |-> alertPending ##1 s_noClear; endproperty
	property p_timeout; lowCount > TIMEOUT_LIMIT + 8 |-> sdaOeN; endproperty
	a_pullOnly: assert property (p_pullOnly)
		else $error("data line driven high");
	a_drvInLow: assert property (p_drvInLow)
		else $error("data moved with clock high");
	a_commitIdle: assert property (p_commitIdle)
		else $error("write outside idle bus");
	a_strobeOnce: assert property (p_strobeOnce)
		else $error("second write strobe");
	a_ptrMove: assert property (p_ptrMove)
		else $error("pointer moved mid byte");
	a_dataMove: assert property (p_dataMove)
		else $error("write data moved early");
	a_strapFans: assert property (p_strapFans)
		else $error("fan pin on in strap mode");
	a_clear: assert property (p_clear)
		else $error("clear without alert");
	a_timeout: assert property (p_timeout)
		else $error("data held after timeout");
endmodule : smbsp_chk

// ==== tb/smbsp_host_model.sv ====
`timescale 1ns/10ps
// ------------------------------------
// Bus master model
// ------------------------------------
module smbsp_host_model
(
	// Timebase
	input wire logic linkClock,
	// Bus
	output logic scl,
	output logic sdaLow,
	input wire logic sdaLine
);
	localparam int QTR = 6;
	// Clock rests high between frames
	initial
	begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic wait_q(input int n);
		repeat (n) @(posedge linkClock);
	endtask : wait_q
	// Data set mid-low, sampled late in the high phase
	task automatic bit_io(input logic b, output logic r);
		wait_q(QTR);
		sdaLow <= !b;
		wait_q(QTR);
		scl <= 1'b1;
		wait_q(QTR);
		r = sdaLine;
		scl <= 1'b0;
	endtask : bit_io
	// Also serves as repeated START from a low clock
	task automatic start_cond;
		wait_q(QTR);
		sdaLow <= 1'b0;
		wait_q(QTR);
		scl <= 1'b1;
		wait_q(QTR);
		sdaLow <= 1'b1;
		wait_q(QTR);
		scl <= 1'b0;
	endtask : start_cond
	task automatic stop_cond;
		wait_q(QTR);
		sdaLow <= 1'b1;
		wait_q(QTR);
		scl <= 1'b1;
		wait_q(QTR);
		sdaLow <= 1'b0;
		wait_q(QTR);
	endtask : stop_cond
	// Eight bits MSB first, then the ACK bit
	task automatic xfer(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ackIn, ack);
	endtask : xfer
endmodule : smbsp_host_model

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
// ------------------------------------
// Register port bench
// ------------------------------------
module testbench
	import smbsp_pkg::*;
;
	localparam int TIMEOUT_LIMIT = 200;
	logic clock = 1'b0;
	logic linkClock = 1'b0;
	logic reset = 1'b1;
	logic clockEnable = 1'b1;
	logic strapEnableN = 1'b1;
	logic strapLevel = 1'b0;
	logic alertPending = 1'b0;
	logic scl, sdaLow, sdaLine, sdaOut, sdaOeN, fan4On, fan3On, strobe, intClear;
	logic [7:0] regAddr, regWriteData, regReadData;
	logic regDefined;
	logic [7:0] mem [0:255];
	int nErrors = 0, nCompared = 0, nStrobe = 0, nClear = 0;
	always #10 clock = ~clock;
	always #24 linkClock = ~linkClock;
	// Pull-up; undefined places read garbage the port must mask
	assign sdaLine = !(sdaLow || (!sdaOeN && !sdaOut));
	assign regDefined = regAddr < 8'h80;
	assign regReadData = regDefined ? mem[regAddr] : 8'h5A;
	// Register file model
	always @(posedge clock)
	begin
		if (strobe)
			nStrobe <= nStrobe + 1;
		if (strobe && regDefined)
			mem[regAddr] <= regWriteData;
		if (intClear)
			nClear <= nClear + 1;
	end
	smbsp_register_port #(.TIMEOUT_LIMIT(TIMEOUT_LIMIT)) dut (.clock(clock), .reset(reset),
		.clockEnable(clockEnable), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
		.sdaOeN(sdaOeN), .strapEnableN(strapEnableN), .strapLevel(strapLevel),
		.fan4TachEnable(fan4On), .fan3PwmEnable(fan3On), .regAddr(regAddr),
		.regWriteData(regWriteData), .regWriteStrobe(strobe), .regReadData(regReadData),
		.regDefined(regDefined), .alertPending(alertPending), .alertIntEnableClear(intClear));
	smbsp_host_model host (.linkClock(linkClock), .scl(scl), .sdaLow(sdaLow), .sdaLine(sdaLine));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic reportAndStop;
		$display("Compared %0d mismatches %0d", nCompared, nErrors);
		if (nErrors == 0 && nCompared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : reportAndStop
	task automatic do_reset(input logic en, input logic lvl);
		@(posedge clock);
		strapEnableN <= en;
		strapLevel <= lvl;
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		repeat (20) @(posedge clock);
	endtask : do_reset
	task automatic put(input logic [7:0] d, output logic ack);
		logic [7:0] q;
		host.xfer(d, 1'b1, q, ack);
	endtask : put
	task automatic write_reg(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d,
		output logic [2:0] acks);
		host.start_cond();
		put({a, 1'b0}, acks[2]);
		put(r, acks[1]);
		put(d, acks[0]);
		host.stop_cond();
	endtask : write_reg
	// Read Byte when setPtr, else Receive Byte
	task automatic read_reg(input logic [6:0] a, input logic setPtr, input logic [7:0] r,
		output logic [7:0] q, output logic ack);
		logic a0;
		host.start_cond();
		if (setPtr)
		begin
			put({a, 1'b0}, a0);
			put(r, a0);
			host.start_cond();
		end
		put({a, 1'b1}, ack);
		host.xfer(8'hFF, 1'b1, q, a0);
		host.stop_cond();
	endtask : read_reg
	task automatic test_write_read;
		logic [2:0] acks;
		logic [7:0] q;
		logic ack;
		int s0 = nStrobe;
		write_reg(DEFAULT_ADDR, 8'h12, 8'hA6, acks);
		check("acks", 8'(acks), 8'h00);
		check("strobes", 8'(nStrobe - s0), 8'h01);
		check("mem", mem[8'h12], 8'hA6);
		read_reg(DEFAULT_ADDR, 1'b1, 8'h12, q, ack);
		check("rd ack", 8'(ack), 8'h00);
		check("rd data", q, 8'hA6);
		write_reg(DEFAULT_ADDR, 8'hF0, 8'h77, acks);
		check("undef acks", 8'(acks), 8'h00);
		read_reg(DEFAULT_ADDR, 1'b1, 8'hF0, q, ack);
		check("undef data", q, 8'h00);
		$display("write and read done");
	endtask : test_write_read
	task automatic test_send_receive;
		logic [7:0] q;
		logic ack;
		int s0 = nStrobe;
		mem[8'h34] = 8'h3B;
		host.start_cond();
		put({DEFAULT_ADDR, 1'b0}, ack);
		put(8'h34, ack);
		host.stop_cond();
		check("send ack", 8'(ack), 8'h00);
		check("no write", 8'(nStrobe - s0), 8'h00);
		repeat (2)
		begin
			read_reg(DEFAULT_ADDR, 1'b0, 8'h00, q, ack);
			check("recv", q, 8'h3B);
		end
		check("pointer", regAddr, 8'h34);
		$display("send and receive done");
	endtask : test_send_receive
	task automatic test_refused;
		logic [6:0] bad [3] = '{GENERAL_CALL_ADDR, 7'h33, ALERT_RESPONSE_ADDR};
		logic [2:0] acks;
		logic [7:0] q;
		logic ack;
		int c0 = nClear;
		for (int i = 0; i < 3; i++)
		begin
			write_reg(bad[i], 8'h12, 8'h00, acks);
			check("refused", 8'(acks), 8'h07);
		end
		check("kept", mem[8'h12], 8'hA6);
		read_reg(ALERT_RESPONSE_ADDR, 1'b0, 8'h00, q, ack);
		check("ara quiet", 8'(ack), 8'h01);
		@(posedge clock);
		alertPending <= 1'b1;
		read_reg(ALERT_RESPONSE_ADDR, 1'b0, 8'h00, q, ack);
		check("ara ack", 8'(ack), 8'h00);
		check("ara addr", 8'(q[7:1]), 8'(DEFAULT_ADDR));
		check("clears", 8'(nClear - c0), 8'h01);
		@(posedge clock);
		alertPending <= 1'b0;
		$display("refusals done");
	endtask : test_refused
	task automatic test_invalid;
		logic [7:0] q;
		logic ack;
		int s0 = nStrobe;
		host.start_cond();
		put({DEFAULT_ADDR, 1'b0}, ack);
		put(8'h12, ack);
		put(8'h11, ack);
		put(8'h22, ack);
		check("extra", 8'(ack), 8'h01);
		host.stop_cond();
		host.start_cond();
		put({DEFAULT_ADDR, 1'b0}, ack);
		put(8'h12, ack);
		put(8'h99, ack);
		host.start_cond();
		host.stop_cond();
		check("no commit", 8'(nStrobe - s0), 8'h00);
		read_reg(DEFAULT_ADDR, 1'b1, 8'h12, q, ack);
		check("after abort", q, 8'hA6);
		$display("invalid protocols done");
	endtask : test_invalid
	// Stretch in the address ACK, then hang while the port drives
	task automatic test_timeout;
		logic [7:0] b = {DEFAULT_ADDR, 1'b1};
		logic [7:0] q;
		logic r;
		host.start_cond();
		for (int i = 7; i >= 0; i--)
			host.bit_io(b[i], r);
		host.wait_q(20);
		host.bit_io(1'b1, r);
		check("stretch ack", 8'(r), 8'h00);
		host.bit_io(1'b1, r);
		check("bit7", 8'(r), 8'h01);
		host.wait_q(125);
		check("released", 8'(sdaLine), 8'h01);
		host.stop_cond();
		read_reg(DEFAULT_ADDR, 1'b1, 8'h12, q, r);
		check("recovered", q, 8'hA6);
		$display("timeout done");
	endtask : test_timeout
	task automatic test_strap;
		logic [6:0] own;
		logic [7:0] q;
		logic ack;
		for (int lvl = 0; lvl < 2; lvl++)
		begin
			do_reset(1'b0, lvl[0]);
			own = lvl[0] ? STRAP_ADDR_HIGH : STRAP_ADDR_LOW;
			check("fans off", {6'h00, fan4On, fan3On}, 8'h00);
			read_reg(own, 1'b1, 8'h12, q, ack);
			check("strap ack", 8'(ack), 8'h00);
			@(posedge clock);
			strapLevel <= !strapLevel;
			read_reg(own, 1'b1, 8'h12, q, ack);
			check("latched", 8'(ack), 8'h00);
			read_reg(DEFAULT_ADDR, 1'b1, 8'h12, q, ack);
			check("default off", 8'(ack), 8'h01);
		end
		do_reset(1'b1, 1'b0);
		check("fans on", {6'h00, fan4On, fan3On}, 8'h03);
		$display("straps done");
	endtask : test_strap
	// Main sequence
	initial
	begin
		do_reset(1'b1, 1'b0);
		test_write_read();
		test_send_receive();
		test_refused();
		test_invalid();
		test_timeout();
		test_strap();
		reportAndStop();
	end
	// Watchdog, nearly three times the expected run
	initial
	begin
		#1_800_000;
		nErrors++;
		reportAndStop();
	end
endmodule : testbench
bind smbsp_register_port smbsp_chk #(.TIMEOUT_LIMIT(TIMEOUT_LIMIT)) chk (.clock(clock),
	.reset(reset), .clockEnable(clockEnable), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
	.sdaOeN(sdaOeN), .strapEnableN(strapEnableN), .strapLevel(strapLevel),
	.fan4TachEnable(fan4TachEnable), .fan3PwmEnable(fan3PwmEnable), .regAddr(regAddr),
	.regWriteData(regWriteData), .regWriteStrobe(regWriteStrobe), .regReadData(regReadData),
	.regDefined(regDefined), .alertPending(alertPending),
	.alertIntEnableClear(alertIntEnableClear));
